// *** verilog/acc_conv_ctrl.sv ***
// Converter control top: AXI4-Lite registers, start, sleep and completion sequencing
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
module acc_conv_ctrl #(
   parameter int RC_CLKS = acc_pkg::RC_BIT_CLKS
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic special_event_trigger,
   input wire logic [9:0] sample_value,
   output acc_pkg::acc_conv_req_s conv_req,
   output logic converter_power,
   output logic timer_one_clear,
   output logic irq,
   output logic wake,
   output logic [29:0] vector_addr,
   output logic vector_take
);
   // ************
   // Register state
   // ************
   logic [7:0] main_q, clkc_q, ansl_q, ansh_q, res_hi_q, res_lo_q, sysc_q;
   logic flag_q, en_q, gie_q, peripheral_irq_enable_q;
   logic [1:0] trig_sync_q;
   logic trig_prev_q;
   acc_pkg::acc_state_e state_q;
   logic [2:0] bits_q;
   logic [3:0] bitcnt_q;
   logic [1:0] dly_q;
   // ************
   // AXI4-Lite slave
   // ************
   logic aw_q, w_q;
   logic [11:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   wire logic do_wr = aw_q && w_q && !s_axi_bvalid;
   wire logic [8:0] widx = awaddr_q[10:2];
   wire logic [8:0] ridx = s_axi_araddr[10:2];
   wire logic wlane = wstrb_q[0];
   wire logic [7:0] wb = wdata_q[7:0];
   function automatic logic hit(input logic [8:0] idx, input logic [8:0] reg_idx);
      hit = idx == reg_idx;
   endfunction
   wire logic wr_main = do_wr && wlane && hit(widx, acc_pkg::IDX_MAIN_CTRL);
   wire logic wr_flag = do_wr && wlane && hit(widx, acc_pkg::IDX_FLAG);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_q <= 1'b0;
         w_q <= 1'b0;
         awaddr_q <= 12'h000;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
         s_axi_bvalid <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         if (do_wr) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_arready <= 1'b0;
      end else begin
         s_axi_awready <= !aw_q && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
         s_axi_wready <= !w_q && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
         s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      end
   end
   assign s_axi_bresp = 2'b00;
   assign s_axi_rresp = 2'b00;
   wire logic [7:0] rbyte =
      hit(ridx, acc_pkg::IDX_RES_HIGH) ? res_hi_q :
      hit(ridx, acc_pkg::IDX_MAIN_CTRL) ? main_q :
      hit(ridx, acc_pkg::IDX_RES_LOW) ? res_lo_q :
      hit(ridx, acc_pkg::IDX_CLK_CTRL) ? (clkc_q & acc_pkg::CC_MASK) :
      hit(ridx, acc_pkg::IDX_PINSEL_LOW) ? ansl_q :
      hit(ridx, acc_pkg::IDX_PINSEL_HIGH) ? (ansh_q & acc_pkg::ANSH_MASK) :
      hit(ridx, acc_pkg::IDX_FLAG) ? {1'b0, flag_q, 6'h00} :
      hit(ridx, acc_pkg::IDX_ENABLE) ? {1'b0, en_q, 6'h00} :
      hit(ridx, acc_pkg::IDX_IRQ_CTRL) ? {gie_q, peripheral_irq_enable_q, 6'h00} :
      hit(ridx, acc_pkg::IDX_SYS_CTRL) ? sysc_q : 8'h00;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= {24'h000000, rbyte};
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
   // ************
   // Control decode
   // ************
   wire logic conv_on = main_q[acc_pkg::MC_ON];
   wire logic [2:0] csel = clkc_q[acc_pkg::CC_SEL_LSB +: 3];
   wire logic rc_clk = csel[1:0] == 2'b11;
   wire logic sleeping = sysc_q[acc_pkg::SC_SLEEP];
   wire logic [3:0] ccm = sysc_q[acc_pkg::SC_CCM_LSB +: 4];
   wire logic trig_edge = trig_sync_q[1] && !trig_prev_q;
   wire logic trig_start = trig_edge && ccm == acc_pkg::CCM_SPECIAL_EVENT && conv_on;
   wire logic sw_go = wr_main && wb[acc_pkg::MC_GO] && !main_q[acc_pkg::MC_GO];
   wire logic sw_abort = wr_main && !wb[acc_pkg::MC_GO] && main_q[acc_pkg::MC_GO];
   wire logic sleep_abort = sleeping && !rc_clk && state_q != acc_pkg::ACC_IDLE;
   wire logic run = conv_on && !(sleeping && !rc_clk) && state_q != acc_pkg::ACC_IDLE;
   wire logic tick;
   wire logic conv_end = state_q == acc_pkg::ACC_CONV && tick &&
      bitcnt_q == 4'(acc_pkg::RESULT_BITS - 1);
   wire logic irq_armed = en_q && peripheral_irq_enable_q;
   wire logic [9:0] sv = sample_value;
   wire logic [7:0] nhi = main_q[acc_pkg::MC_JUSTIFY] ? {6'h00, sv[9:8]} : sv[9:2];
   wire logic [7:0] nlo = main_q[acc_pkg::MC_JUSTIFY] ? sv[7:0] : {sv[1:0], 6'h00};
   acc_tick_gen #(.RC_CLKS(RC_CLKS)) u_tick (
      .aclk(aclk),
      .aresetn(aresetn),
      .run(run),
      .sel(csel),
      .tick(tick)
   );
   // ************
   // Trigger synchroniser
   // ************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         trig_sync_q <= 2'b00;
         trig_prev_q <= 1'b0;
      end else begin
         trig_sync_q <= {trig_sync_q[0], special_event_trigger};
         trig_prev_q <= trig_sync_q[1];
      end
   end
   // ************
   // Sequencer
   // ************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q <= acc_pkg::ACC_IDLE;
         bitcnt_q <= 4'h0;
         dly_q <= 2'd0;
         bits_q <= 3'd0;
      end else if (!conv_on || sleep_abort) begin
         state_q <= acc_pkg::ACC_IDLE;
      end else begin
         case (state_q)
            acc_pkg::ACC_IDLE: begin
               if (sw_go || trig_start) begin
                  state_q <= rc_clk ? acc_pkg::ACC_DELAY : acc_pkg::ACC_CONV;
                  dly_q <= 2'(acc_pkg::INSTR_CYCLE_CLKS - 1);
                  bitcnt_q <= 4'h0;
               end
            end
            acc_pkg::ACC_DELAY: begin
               if (sw_abort) begin
                  state_q <= acc_pkg::ACC_SETTLE;
                  bits_q <= 3'd0;
               end else if (dly_q == 2'd0) begin
                  state_q <= acc_pkg::ACC_CONV;
               end else begin
                  dly_q <= dly_q - 2'd1;
               end
            end
            acc_pkg::ACC_CONV: begin
               if (sw_abort || conv_end) begin
                  state_q <= acc_pkg::ACC_SETTLE;
                  bits_q <= 3'd0;
               end else if (tick) begin
                  bitcnt_q <= bitcnt_q + 4'h1;
               end
            end
            acc_pkg::ACC_SETTLE: begin
               if (tick) begin
                  bits_q <= bits_q + 3'd1;
                  if (bits_q == 3'(acc_pkg::SETTLE_BIT_PERIODS - 1)) begin
                     state_q <= acc_pkg::ACC_IDLE;
                  end
               end
            end
            default: state_q <= acc_pkg::ACC_IDLE;
         endcase
      end
   end
   // ************
   // Software registers
   // ************
   wire logic go_now = state_q == acc_pkg::ACC_IDLE && (sw_go || trig_start);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         main_q <= acc_pkg::RST_MAIN_CTRL;
         clkc_q <= acc_pkg::RST_CLK_CTRL;
         ansl_q <= acc_pkg::RST_PINSEL_LOW;
         ansh_q <= acc_pkg::RST_PINSEL_HIGH;
         sysc_q <= 8'h00;
         en_q <= 1'b0;
         gie_q <= 1'b0;
         peripheral_irq_enable_q <= 1'b0;
      end else begin
         if (wr_main) begin
            main_q <= {wb[7:2], main_q[acc_pkg::MC_GO] && wb[acc_pkg::MC_GO], wb[acc_pkg::MC_ON]};
         end
         if (go_now && conv_on) begin
            main_q[acc_pkg::MC_GO] <= 1'b1;
         end else if (conv_end || sleep_abort || (state_q == acc_pkg::ACC_IDLE && !go_now)) begin
            main_q[acc_pkg::MC_GO] <= 1'b0;
         end
         if (do_wr && wlane && hit(widx, acc_pkg::IDX_CLK_CTRL)) clkc_q <= wb & acc_pkg::CC_MASK;
         if (do_wr && wlane && hit(widx, acc_pkg::IDX_PINSEL_LOW)) ansl_q <= wb;
         if (do_wr && wlane && hit(widx, acc_pkg::IDX_PINSEL_HIGH)) ansh_q <= wb & acc_pkg::ANSH_MASK;
         if (do_wr && wlane && hit(widx, acc_pkg::IDX_ENABLE)) en_q <= wb[acc_pkg::EN_DONE];
         if (do_wr && wlane && hit(widx, acc_pkg::IDX_SYS_CTRL)) sysc_q <= wb;
         if (do_wr && wlane && hit(widx, acc_pkg::IDX_IRQ_CTRL)) begin
            gie_q <= wb[acc_pkg::IC_GLOBAL];
            peripheral_irq_enable_q <= wb[acc_pkg::IC_PERIPH];
         end
         if (conv_end && sleeping && irq_armed) begin
            sysc_q[acc_pkg::SC_SLEEP] <= 1'b0;
         end
      end
   end
   // ************
   // Result, flag and outputs
   // ************
   always_ff @(posedge aclk) begin
      if (conv_end) begin
         res_hi_q <= nhi;
         res_lo_q <= nlo;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flag_q <= 1'b0;
      end else if (conv_end) begin
         flag_q <= 1'b1;
      end else if (wr_flag) begin
         flag_q <= wb[acc_pkg::FLAG_DONE];
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         conv_req <= '0;
         converter_power <= 1'b0;
         timer_one_clear <= 1'b0;
         irq <= 1'b0;
         wake <= 1'b0;
         vector_addr <= 30'h0;
         vector_take <= 1'b0;
      end else begin
         conv_req.start <= state_q == acc_pkg::ACC_DELAY && dly_q == 2'd0 ||
            state_q == acc_pkg::ACC_IDLE && go_now && !rc_clk;
         conv_req.channel <= main_q[acc_pkg::MC_CHAN_LSB +: 4];
         conv_req.refsel <= main_q[acc_pkg::MC_REFSEL];
         converter_power <= conv_on && !(sleeping && (!rc_clk || (!irq_armed && state_q == acc_pkg::ACC_IDLE)));
         timer_one_clear <= trig_edge && ccm == acc_pkg::CCM_SPECIAL_EVENT;
         irq <= flag_q && irq_armed && gie_q;
         wake <= conv_end && sleeping && irq_armed;
         vector_take <= conv_end && sleeping && irq_armed && gie_q;
         vector_addr <= acc_pkg::VECTOR_ADDR;
      end
   end
endmodule
`default_nettype wire

// *** verilog/acc_pkg.sv ***
// Package with register map, field layout, reset values and timing for the converter control
package acc_pkg;
   // Register indices (offsets are all multiples of four: byte address = 4 * index)
   localparam logic [8:0] IDX_RES_HIGH = 9'h01e;
   localparam logic [8:0] IDX_MAIN_CTRL = 9'h01f;
   localparam logic [8:0] IDX_RES_LOW = 9'h09e;
   localparam logic [8:0] IDX_CLK_CTRL = 9'h09f;
   localparam logic [8:0] IDX_PINSEL_LOW = 9'h11e;
   localparam logic [8:0] IDX_PINSEL_HIGH = 9'h11f;
   localparam logic [8:0] IDX_FLAG = 9'h00c;
   localparam logic [8:0] IDX_ENABLE = 9'h08c;
   localparam logic [8:0] IDX_IRQ_CTRL = 9'h00b;
   localparam logic [8:0] IDX_SYS_CTRL = 9'h100;
   // Main control fields
   localparam int MC_JUSTIFY = 7;
   localparam int MC_REFSEL = 6;
   localparam int MC_CHAN_LSB = 2;
   localparam int MC_GO = 1;
   localparam int MC_ON = 0;
   // Clock control field
   localparam int CC_SEL_LSB = 4;
   localparam logic [7:0] CC_MASK = 8'h70;
   localparam logic [7:0] ANSH_MASK = 8'h0f;
   // Flag, enable and interrupt control bit positions
   localparam int FLAG_DONE = 6;
   localparam int EN_DONE = 6;
   localparam int IC_GLOBAL = 7;
   localparam int IC_PERIPH = 6;
   // System control register: bit 0 sleep request, bits 7:4 capture/compare mode
   localparam int SC_SLEEP = 0;
   localparam int SC_CCM_LSB = 4;
   localparam logic [3:0] CCM_SPECIAL_EVENT = 4'hb;
   // Reset values
   localparam logic [7:0] RST_MAIN_CTRL = 8'h00;
   localparam logic [7:0] RST_CLK_CTRL = 8'h00;
   localparam logic [7:0] RST_PINSEL_LOW = 8'hff;
   localparam logic [7:0] RST_PINSEL_HIGH = 8'h0f;
   // Timing
   localparam int CLK_HZ = 20000000;
   localparam int RESULT_BITS = 10;
   localparam int SETTLE_BIT_PERIODS = 2;
   localparam int INSTR_CYCLE_CLKS = 4;
   localparam int RC_BIT_PERIOD_NS = 4000;
   localparam int RC_BIT_CLKS = (RC_BIT_PERIOD_NS * (CLK_HZ / 1000000)) / 1000;
   localparam logic [29:0] VECTOR_ADDR = 30'h0004;
   typedef enum logic [2:0] {
      ACC_IDLE = 3'b000,
      ACC_DELAY = 3'b001,
      ACC_CONV = 3'b011,
      ACC_SETTLE = 3'b010
   } acc_state_e;
   typedef struct packed {
      logic start;
      logic [3:0] channel;
      logic refsel;
   } acc_conv_req_s;
endpackage

// *** verilog/acc_tick_gen.sv ***
// Conversion bit period enable generator
`timescale 1ns/10ps
`default_nettype none
module acc_tick_gen #(
   parameter int RC_CLKS = 80
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic run,
   input wire logic [2:0] sel,
   output logic tick
);
   // ************
   // Divider
   // ************
   logic [6:0] cnt_q;
   logic [6:0] limit;
   function automatic logic [6:0] div_limit(input logic [2:0] s);
      case (s)
         3'b000: div_limit = 7'd1;
         3'b100: div_limit = 7'd3;
         3'b001: div_limit = 7'd7;
         3'b101: div_limit = 7'd15;
         3'b010: div_limit = 7'd31;
         3'b110: div_limit = 7'd63;
         default: div_limit = 7'(RC_CLKS - 1);
      endcase
   endfunction
   assign limit = div_limit(sel);
   always_ff @(posedge aclk) begin
      if (!aresetn || !run || cnt_q >= limit) begin
         cnt_q <= 7'd0;
      end else begin
         cnt_q <= cnt_q + 7'd1;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tick <= 1'b0;
      end else begin
         tick <= run && cnt_q >= limit;
      end
   end
endmodule
`default_nettype wire

// *** tb/acc_core_model.sv ***
// Analog multiplexer and sample-hold core model
`timescale 1ns/10ps
`default_nettype none
module acc_core_model (
   input wire logic aclk,
   input wire acc_pkg::acc_conv_req_s conv_req,
   input wire logic converter_power,
   input wire logic [9:0] next_val,
   output logic [9:0] sample_value
);
   // ************************************
   // Sample held from start until converter power drops
   // ************************************
   logic held_q = 1'h0;
   initial sample_value = 10'h155;
   always @(posedge aclk) begin
      if (conv_req.start) begin
         held_q <= 1'h1;
         sample_value <= next_val;
      end else if (!converter_power || !held_q) begin
         held_q <= 1'h0;
         sample_value <= ~sample_value;
      end
   end
endmodule
`default_nettype wire

// *** tb/acc_conv_ctrl_chk.sv ***
// Concurrent port checks for the converter control block
`timescale 1ns/10ps
`default_nettype none
module acc_conv_ctrl_chk (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic special_event_trigger,
   input wire acc_pkg::acc_conv_req_s conv_req,
   input wire logic converter_power,
   input wire logic timer_one_clear,
   input wire logic irq,
   input wire logic wake,
   input wire logic [29:0] vector_addr,
   input wire logic vector_take
);
   // ******
   // Checks
   // ******
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_go; conv_req.start; endsequence
   sequence s_quiet; !conv_req.start [*8]; endsequence
   property p_go_gap; s_go |=> s_quiet; endproperty
   a_go_gap: assert property (p_go_gap) else $error("start pulses too close");
   property p_go_on; s_go |-> converter_power; endproperty
   a_go_on: assert property (p_go_on) else $error("start while powered down");
   property p_rst; $rose(aresetn) |-> !converter_power && !irq && !conv_req.start; endproperty
   a_rst: assert property (p_rst) else $error("outputs active after reset");
   property p_tclr; timer_one_clear |-> $past(special_event_trigger) ##1 !timer_one_clear; endproperty
   a_tclr: assert property (p_tclr) else $error("timer clear without trigger");
   property p_wake; wake |=> !wake; endproperty
   a_wake: assert property (p_wake) else $error("wake not a pulse");
   property p_vec; vector_take |-> wake && vector_addr == acc_pkg::VECTOR_ADDR; endproperty
   a_vec: assert property (p_vec) else $error("bad vector");
   property p_rd; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
   a_rd: assert property (p_rd) else $error("read answer late");
   property p_rone; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
   a_rone: assert property (p_rone) else $error("read answer repeated");
   property p_bone; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
   a_bone: assert property (p_bone) else $error("write answer repeated");
endmodule
`default_nettype wire

// *** tb/tb_adc_conversion_control.sv ***
// Self-checking testbench for the converter control block
`timescale 1ns/10ps
`default_nettype none
module tb_adc_conversion_control;
   // *******************
   // Signals and devices
   // *******************
   logic aclk = 1'h0, aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0;
   logic rready = 1'h0, trig = 1'h0, awr, wr_y, bvalid, arr, rvalid, pw, tclr, irq, wake, vtake, irq_d = 1'h0;
   logic [11:0] awaddr = 12'h000, araddr = 12'h000;
   logic [31:0] wdata = 32'h0, rdata;
   logic [1:0] bresp, rresp;
   logic [9:0] sv, nv = 10'h000;
   logic [29:0] vaddr;
   logic [4:0] cs = 5'h00;
   logic [15:0] exp_q[$];
   acc_pkg::acc_conv_req_s cr;
   int err_total = 0, tests_run = 0, n_st = 0, n_tc = 0, n_wk = 0, n_vt = 0, cyc = 0, t_st = 0, t_irq = 0;
   always #25 aclk = ~aclk;
   acc_conv_ctrl #(.RC_CLKS(4)) dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awr), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1),
      .s_axi_wvalid(wvalid), .s_axi_wready(wr_y), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arr),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .special_event_trigger(trig), .sample_value(sv), .conv_req(cr), .converter_power(pw),
      .timer_one_clear(tclr), .irq(irq), .wake(wake), .vector_addr(vaddr), .vector_take(vtake));
   acc_core_model core (.aclk(aclk), .conv_req(cr), .converter_power(pw), .next_val(nv), .sample_value(sv));
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      irq_d <= irq;
      if (irq === 1'h1 && irq_d !== 1'h1) t_irq <= cyc;
      if (cr.start === 1'h1) begin
         n_st <= n_st + 1;
         t_st <= cyc;
         cs <= {cr.channel, cr.refsel};
      end
      if (tclr === 1'h1) n_tc <= n_tc + 1;
      if (wake === 1'h1) n_wk <= n_wk + 1;
      if (vtake === 1'h1) n_vt <= n_vt + 1;
   end
   // *****
   // Tasks
   // *****
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic tmo(input int n);
      if (n >= 4000) begin
         err_total++;
         $display("unexpected wait: expected answer seen none");
         test_done;
      end
   endtask
   task automatic wr(input logic [8:0] i, input logic [7:0] d);
      int n;
      @(posedge aclk);
      awaddr <= {1'h0, i, 2'h0};
      wdata <= {24'h0, d};
      {awvalid, wvalid, bready} <= 3'h7;
      for (n = 0; n < 4000; n++) begin
         @(posedge aclk);
         if (awr) awvalid <= 1'h0;
         if (wr_y) wvalid <= 1'h0;
         if (bvalid) break;
      end
      bready <= 1'h0;
      chk("write response", bresp, 32'h0);
      tmo(n);
   endtask
   task automatic rd(input logic [8:0] i, output logic [7:0] d);
      int n;
      @(posedge aclk);
      araddr <= {1'h0, i, 2'h0};
      {arvalid, rready} <= 2'h3;
      for (n = 0; n < 4000; n++) begin
         @(posedge aclk);
         if (arr) arvalid <= 1'h0;
         if (rvalid) break;
      end
      d = rdata[7:0];
      chk("read response", rresp, 32'h0);
      rready <= 1'h0;
      tmo(n);
   endtask
   task automatic rc(input string nm, input logic [8:0] i, input logic [7:0] e);
      logic [7:0] d;
      rd(i, d);
      chk(nm, d, e);
   endtask
   task automatic idle;
      logic [7:0] d;
      int n;
      d = 8'h02;
      for (n = 0; n < 4000 && d[1]; n++) rd(acc_pkg::IDX_MAIN_CTRL, d);
      tmo(n);
   endtask
   task automatic go(input logic [7:0] m, input logic push);
      nv <= 10'($urandom);
      wr(acc_pkg::IDX_MAIN_CTRL, m | 8'h01);
      wr(acc_pkg::IDX_MAIN_CTRL, m | 8'h03);
      if (push) exp_q.push_back(m[7] ? {6'h0, nv} : {nv, 6'h00});
   endtask
   task automatic res;
      rc("result high", acc_pkg::IDX_RES_HIGH, exp_q[$][15:8]);
      rc("result low", acc_pkg::IDX_RES_LOW, exp_q[$][7:0]);
   endtask
   task automatic pulse(input logic [7:0] m, input int ds, input int dt);
      int s;
      int t;
      wr(acc_pkg::IDX_MAIN_CTRL, m);
      s = n_st;
      t = n_tc;
      @(posedge aclk) trig <= 1'h1;
      repeat (8) @(posedge aclk);
      trig <= 1'h0;
      idle;
      chk("trigger start", n_st - s, ds);
      chk("timer clear", n_tc - t, dt);
   endtask
   // *************
   // Main sequence
   // *************
   initial begin
      logic [7:0] d;
      logic [7:0] m;
      int s, n, k, j, tg;
      void'($urandom(62509));
      repeat (20) @(posedge aclk);
      aresetn <= 1'h1;
      rc("main reset", acc_pkg::IDX_MAIN_CTRL, 8'h00);
      rc("clock reset", acc_pkg::IDX_CLK_CTRL, 8'h00);
      rc("pin low reset", acc_pkg::IDX_PINSEL_LOW, 8'hff);
      rc("pin high reset", acc_pkg::IDX_PINSEL_HIGH, 8'h0f);
      rc("unmapped", 9'h1aa, 8'h00);
      wr(acc_pkg::IDX_CLK_CTRL, 8'hff);
      rc("clock mask", acc_pkg::IDX_CLK_CTRL, 8'h70);
      wr(acc_pkg::IDX_ENABLE, 8'h40);
      wr(acc_pkg::IDX_IRQ_CTRL, 8'hc0);
      for (s = 0; s < 8; s++) begin
         k = (s[1:0] == 2'h3) ? 4 : 2 << {s[1:0], s[2]};
         wr(acc_pkg::IDX_CLK_CTRL, 8'(s << 4));
         m = {1'($urandom), 1'($urandom), 4'($urandom % 12), 2'h0};
         go(m, 1'h1);
         for (n = 0; n < 4000 && irq !== 1'h1; n++) @(posedge aclk);
         tmo(n);
         res;
         rc("busy clear", acc_pkg::IDX_MAIN_CTRL, m | 8'h01);
         rd(acc_pkg::IDX_FLAG, d);
         chk("done flag", d[6], 1'h1);
         chk("conv time", (t_irq - t_st >= 9 * k) && (t_irq - t_st <= 12 * k + 8), 1'h1);
         chk("request", cs, {m[5:2], m[6]});
         wr(acc_pkg::IDX_FLAG, 8'h00);
         repeat (2) @(posedge aclk);
         chk("irq clear", irq, 1'h0);
         // Two bit periods of settling before the clock or go changes
         repeat (2 * k) @(posedge aclk);
      end
      wr(acc_pkg::IDX_MAIN_CTRL, 8'h00);
      s = n_st;
      wr(acc_pkg::IDX_MAIN_CTRL, 8'h03);
      repeat (20) @(posedge aclk);
      chk("go at turn-on", n_st, s);
      wr(acc_pkg::IDX_CLK_CTRL, 8'h60);
      go(8'h81, 1'h0);
      repeat (40) @(posedge aclk);
      wr(acc_pkg::IDX_MAIN_CTRL, 8'h81);
      repeat (800) @(posedge aclk);
      res;
      rd(acc_pkg::IDX_FLAG, d);
      chk("abort flag", d[6], 1'h0);
      wr(acc_pkg::IDX_CLK_CTRL, 8'h00);
      wr(acc_pkg::IDX_SYS_CTRL, 8'hb0);
      nv <= 10'($urandom);
      pulse(8'h81, 1, 1);
      exp_q.push_back({6'h0, nv});
      res;
      pulse(8'h00, 0, 1);
      wr(acc_pkg::IDX_SYS_CTRL, 8'ha0);
      pulse(8'h81, 0, 0);
      wr(acc_pkg::IDX_SYS_CTRL, 8'h00);
      wr(acc_pkg::IDX_CLK_CTRL, 8'h70);
      for (s = 0; s < 2; s++) begin
         wr(acc_pkg::IDX_IRQ_CTRL, {1'(s), 7'h40});
         wr(acc_pkg::IDX_FLAG, 8'h00);
         k = n_wk;
         j = n_vt;
         go(8'h81, 1'h1);
         tg = cyc;
         wr(acc_pkg::IDX_SYS_CTRL, 8'h01);
         for (n = 0; n < 4000 && n_wk == k; n++) @(posedge aclk);
         tmo(n);
         repeat (2) @(posedge aclk);
         chk("vector", n_vt - j, s);
         chk("rc delay", t_st - tg >= 2, 1'h1);
         res;
         wr(acc_pkg::IDX_SYS_CTRL, 8'h00);
      end
      wr(acc_pkg::IDX_ENABLE, 8'h00);
      go(8'h81, 1'h1);
      wr(acc_pkg::IDX_SYS_CTRL, 8'h01);
      idle;
      // Power drops once the two settling bit periods are over
      repeat (12) @(posedge aclk);
      chk("sleep power", pw, 1'h0);
      rc("sleep on bit", acc_pkg::IDX_MAIN_CTRL, 8'h81);
      res;
      wr(acc_pkg::IDX_SYS_CTRL, 8'h00);
      wr(acc_pkg::IDX_CLK_CTRL, 8'h60);
      wr(acc_pkg::IDX_MAIN_CTRL, 8'h00);
      go(8'h81, 1'h0);
      repeat (30) @(posedge aclk);
      wr(acc_pkg::IDX_SYS_CTRL, 8'h01);
      repeat (4) @(posedge aclk);
      chk("abort power", pw, 1'h0);
      rd(acc_pkg::IDX_MAIN_CTRL, d);
      chk("abort on bit", d[0], 1'h1);
      res;
      wr(acc_pkg::IDX_SYS_CTRL, 8'h00);
      go(8'h81, 1'h0);
      repeat (20) @(posedge aclk);
      aresetn <= 1'h0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'h1;
      repeat (2) @(posedge aclk);
      chk("reset power", pw, 1'h0);
      rc("main after reset", acc_pkg::IDX_MAIN_CTRL, 8'h00);
      rc("clock after reset", acc_pkg::IDX_CLK_CTRL, 8'h00);
      res;
      test_done;
   end
endmodule
bind acc_conv_ctrl acc_conv_ctrl_chk u_chk (.aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .special_event_trigger(special_event_trigger),
   .conv_req(conv_req), .converter_power(converter_power), .timer_one_clear(timer_one_clear), .irq(irq),
   .wake(wake), .vector_addr(vector_addr), .vector_take(vector_take));
`default_nettype wire
